// >>> logic/kit_port_timer.sv
// Purpose: Key scan port, sense inputs, control registers, timer and IR output
// Assumes: Register port with read data one cycle after the read strobe
// Notes: Pin inputs are synchronised by two flip-flops before use
`timescale 1ns/1ps
`default_nettype none

module kit_port_timer (
	input wire logic mclk, // System clock fx, 25 MHz
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic [2:0] regAddr, // Register index
	input wire logic [7:0] regWdata, // Write data
	input wire logic regWe, // Write strobe
	input wire logic regRe, // Read strobe
	output logic [7:0] regRdata, // Read data, cycle after strobe
	input wire logic [7:0] scanPinIn, // Scan port pin levels
	output logic [7:0] scanPinOut, // Scan port output latch
	output logic scanPinOe_n, // Scan port drive enable, low drives
	output logic scanPullEn, // Scan port pull-downs connected
	input wire logic [3:0] keyReturnIn, // Key-return pin levels
	output logic keyPullEn, // Key-return pull-downs connected
	input wire logic firstSenseInput, // First sense pin level
	output logic firstSenseEnable, // First sense input buffer on
	output logic firstSensePullEn, // First sense pull-down connected
	input wire logic senseIndicatorPinIn, // Combined pin level
	output logic senseIndicatorPinOut, // Combined pin drive value
	output logic senseIndicatorPinOe_n, // Combined pin drive enable, low drives
	output logic senseIndicatorPullEn, // Combined pin pull-down connected
	output logic irTransmitPin, // Infrared transmit output
	output logic [1:0] romPointerHigh, // ROM pointer bits nine and eight
	output logic timerDone // Timer stopped, releases timer halt
);

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [7:0] scanLatch_q;
	logic [7:0] ctl0_q;
	logic [7:0] ctl1_q;
	logic [7:0] timerStage_q;
	logic [8:0] count_q;
	logic timerOutEn_q;
	logic running_q;
	logic burst_q;
	logic [7:0] tickCnt_q;
	logic tick;
	logic startLoad;
	logic carrierHigh;
	logic burstNext;
	logic [8:0] loadValue;
	logic loadIsZero;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [7:0] scanMeta_q;
	logic [7:0] scanSync_q;
	logic [3:0] keyMeta_q;
	logic [3:0] keySync_q;
	logic [1:0] senseMeta_q;
	logic [1:0] senseSync_q;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			scanMeta_q <= 8'h00;
			scanSync_q <= 8'h00;
		end else begin
			scanMeta_q <= scanPinIn;
			scanSync_q <= scanMeta_q;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			keyMeta_q <= 4'h0;
			keySync_q <= 4'h0;
		end else begin
			keyMeta_q <= keyReturnIn;
			keySync_q <= keyMeta_q;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			senseMeta_q <= 2'b00;
			senseSync_q <= 2'b00;
		end else begin
			senseMeta_q <= {senseIndicatorPinIn, firstSenseInput};
			senseSync_q <= senseMeta_q;
		end
	end

	// ----------------------------------------------------------------
	// Mode decode
	// ----------------------------------------------------------------
	logic scanIsOutput;
	logic sense0IsInput;
	logic indicatorIsOutput;
	logic gateOff;
	logic halfRate;

	assign scanIsOutput = ctl1_q[kit_pkg::CTL1_SCAN_MODE];
	assign sense0IsInput = ctl1_q[kit_pkg::CTL1_SENSE0_MODE];
	assign indicatorIsOutput = ctl1_q[kit_pkg::CTL1_INDICATOR_MODE];
	assign gateOff = ctl0_q[kit_pkg::CTL0_CARRIER_GATE];
	assign halfRate = ctl0_q[kit_pkg::CTL0_DIVIDE_RATIO_SELECT];

	// ----------------------------------------------------------------
	// Register write decode
	// ----------------------------------------------------------------
	function automatic logic write_hit(input logic we, input logic [2:0] addr,
		input logic [2:0] idx);
		write_hit = we && addr == idx;
	endfunction : write_hit

	// ----------------------------------------------------------------
	// Scan port latch
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!rst_n)
			scanLatch_q <= kit_pkg::SCAN_RESET;
		else if (write_hit(regWe, regAddr, kit_pkg::REG_KEY_SCAN_PORT))
			scanLatch_q <= regWdata;
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!rst_n)
			ctl0_q <= kit_pkg::CTL0_RESET;
		else if (write_hit(regWe, regAddr, kit_pkg::REG_CARRIER_TIMER_CONTROL))
			ctl0_q <= regWdata & kit_pkg::CTL0_MASK;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			ctl1_q <= kit_pkg::CTL1_RESET;
		else if (write_hit(regWe, regAddr, kit_pkg::REG_PIN_MODE_CONTROL))
			ctl1_q <= regWdata & kit_pkg::CTL1_MASK;
	end

	// ----------------------------------------------------------------
	// Timer load
	// ----------------------------------------------------------------
	// The low byte is staged; writing the high register loads all nine bits
	assign startLoad = write_hit(regWe, regAddr, kit_pkg::REG_TIMER_HIGH);
	assign loadValue = {regWdata[kit_pkg::TMRH_COUNT_BIT_EIGHT], timerStage_q};
	assign loadIsZero = loadValue == 9'h000;

	always_ff @(posedge mclk) begin
		if (!rst_n)
			timerStage_q <= 8'h00;
		else if (write_hit(regWe, regAddr, kit_pkg::REG_TIMER_LOW))
			timerStage_q <= regWdata;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			timerOutEn_q <= 1'b0;
		else if (startLoad)
			timerOutEn_q <= regWdata[kit_pkg::TMRH_OUTPUT_ENABLE];
	end

	// ----------------------------------------------------------------
	// Timer tick prescaler
	// ----------------------------------------------------------------
	// Restarted on load so the run lasts exactly whole ticks
	assign tick = tickCnt_q == (halfRate ? kit_pkg::TICK_DIV_HALF : kit_pkg::TICK_DIV_FULL)
		- 8'h01;

	always_ff @(posedge mclk) begin
		if (!rst_n || startLoad || tick)
			tickCnt_q <= 8'h00;
		else
			tickCnt_q <= tickCnt_q + 8'h01;
	end

	// ----------------------------------------------------------------
	// Down counter and zero detect
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!rst_n)
			count_q <= 9'h000;
		else if (startLoad)
			count_q <= loadValue;
		else if (tick && count_q != 9'h000)
			count_q <= count_q - 9'h001;
	end

	// Running ends on the tick after the count reaches zero: loaded plus one ticks
	always_ff @(posedge mclk) begin
		if (!rst_n)
			running_q <= 1'b0;
		else if (startLoad)
			running_q <= !loadIsZero;
		else if (tick && count_q == 9'h000)
			running_q <= 1'b0;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			timerDone <= 1'b1;
		else if (startLoad)
			timerDone <= loadIsZero;
		else if (tick && count_q == 9'h000)
			timerDone <= 1'b1;
	end

	// ----------------------------------------------------------------
	// Carrier generator
	// ----------------------------------------------------------------
	kit_carrier_gen u_carrier (
		.mclk(mclk),
		.rst_n(rst_n),
		.carrierSel(ctl0_q[kit_pkg::CTL0_CARRIER_SELECT_HIGH:kit_pkg::CTL0_CARRIER_SELECT_LOW]),
		.halfRate(halfRate),
		.restart(startLoad),
		.carrierHigh(carrierHigh)
	);

	// ----------------------------------------------------------------
	// Transmit output with carrier synchronous stop
	// ----------------------------------------------------------------
	// A high carrier phase is finished before the burst ends
	assign burstNext = running_q || (burst_q && carrierHigh && !gateOff);

	always_ff @(posedge mclk) begin
		if (!rst_n)
			burst_q <= 1'b0;
		else
			burst_q <= burstNext;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			irTransmitPin <= 1'b0;
		else
			irTransmitPin <= timerOutEn_q && burstNext
				&& (gateOff || carrierHigh);
	end

	// ----------------------------------------------------------------
	// Pin drivers and pull-downs
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			scanPinOut <= kit_pkg::SCAN_RESET;
			scanPinOe_n <= 1'b0;
		end else begin
			scanPinOut <= scanLatch_q;
			scanPinOe_n <= !scanIsOutput;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			senseIndicatorPinOut <= 1'b1;
			senseIndicatorPinOe_n <= 1'b0;
		end else begin
			senseIndicatorPinOut <= !(timerOutEn_q && running_q);
			senseIndicatorPinOe_n <= !indicatorIsOutput;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			scanPullEn <= 1'b0;
		else
			scanPullEn <= !scanIsOutput;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			keyPullEn <= 1'b1;
		else
			keyPullEn <= ctl1_q[kit_pkg::CTL1_KEY_PULL];
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			firstSenseEnable <= 1'b0;
			firstSensePullEn <= 1'b0;
		end else begin
			firstSenseEnable <= sense0IsInput;
			firstSensePullEn <= ctl1_q[kit_pkg::CTL1_SENSE_PULL] && sense0IsInput;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			senseIndicatorPullEn <= 1'b0;
		else
			senseIndicatorPullEn <= ctl1_q[kit_pkg::CTL1_SENSE_PULL]
				&& !indicatorIsOutput;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			romPointerHigh <= 2'b00;
		else
			romPointerHigh <= ctl0_q[kit_pkg::CTL0_ROM_POINTER_BIT_NINE:
				kit_pkg::CTL0_ROM_POINTER_BIT_EIGHT];
	end

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	logic [7:0] readMux;

	always_comb begin
		readMux = 8'h00;
		case (regAddr)
			kit_pkg::REG_KEY_SCAN_PORT:
				readMux = scanIsOutput ? scanLatch_q : scanSync_q;
			kit_pkg::REG_KEY_AND_SENSE_STATUS:
				readMux = {keySync_q, senseSync_q[1],
					sense0IsInput ? senseSync_q[0] : 1'b1, 2'b11};
			kit_pkg::REG_CARRIER_TIMER_CONTROL:
				readMux = ctl0_q & kit_pkg::CTL0_MASK;
			kit_pkg::REG_PIN_MODE_CONTROL:
				readMux = ctl1_q & kit_pkg::CTL1_MASK;
			kit_pkg::REG_TIMER_LOW:
				readMux = count_q[7:0];
			kit_pkg::REG_TIMER_HIGH:
				readMux = {5'h00, timerDone, timerOutEn_q, count_q[8]};
			default:
				readMux = 8'h00;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			regRdata <= 8'h00;
		else if (regRe)
			regRdata <= readMux;
		else
			regRdata <= 8'h00;
	end

endmodule : kit_port_timer

`default_nettype wire

// >>> logic/kit_pkg.sv
// Purpose: Constants for the key port, IR carrier and transmission timer block
// Assumes: Register indices, widths and reset values shared by all design files
// Notes: All counts are in fx (mclk) cycles
//
// Behaviour
// - Scan read: pins when input, latch when output
// - Scan write always updates output latch
// - Scan resets output, all ones; pull-down input only
// - Control1 bit1 selects scan direction
// - Status bits7:4 key pins, bits1:0 read one
// - Control1 bit0 sense input on, else reads one
// - Reset leaves first sense input off
// - Status bit3 shows combined pin level
// - Control1 bit2 selects indicator output, resets high
// - Control1 bits5,4 pull-downs; off in output/off
// - Control0 resets 03h, bits7:6 read zero
// - Control1 resets 26h, bits7,6,3 read zero
// - Control0 bit2 replaces carrier with steady high
// - Control0 bit3 tick 64 or 128, halves carrier
// - Carrier select: fx/8, /64, /96, /96 third
// - Control0 bits5:4 give ROM pointer top bits
// - Nine-bit down counter, enable flag, zero detect
// - Nonzero load starts the timer
// - Decrement per tick; runs loaded plus one ticks
// - Done level holds while stopped; releases halt
// - Enabled: indicator low, transmit high/carrier while running
// - Carrier finishes high phase before stopping

package kit_pkg;

	// ----------------------------------------------------------------
	// Register indices
	// ----------------------------------------------------------------
	localparam logic [2:0] REG_KEY_SCAN_PORT = 3'h0;
	localparam logic [2:0] REG_KEY_AND_SENSE_STATUS = 3'h1;
	localparam logic [2:0] REG_CARRIER_TIMER_CONTROL = 3'h3;
	localparam logic [2:0] REG_PIN_MODE_CONTROL = 3'h4;
	localparam logic [2:0] REG_TIMER_LOW = 3'h5;
	localparam logic [2:0] REG_TIMER_HIGH = 3'h6;

	// ----------------------------------------------------------------
	// Reset values and masks
	// ----------------------------------------------------------------
	localparam logic [7:0] SCAN_RESET = 8'hff;
	localparam logic [7:0] CTL0_RESET = 8'h03;
	localparam logic [7:0] CTL1_RESET = 8'h26;
	localparam logic [7:0] CTL0_MASK = 8'h3f;
	localparam logic [7:0] CTL1_MASK = 8'h37;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTL0_CARRIER_SELECT_LOW = 0;
	localparam int CTL0_CARRIER_SELECT_HIGH = 1;
	localparam int CTL0_CARRIER_GATE = 2;
	localparam int CTL0_DIVIDE_RATIO_SELECT = 3;
	localparam int CTL0_ROM_POINTER_BIT_EIGHT = 4;
	localparam int CTL0_ROM_POINTER_BIT_NINE = 5;
	localparam int CTL1_SENSE0_MODE = 0;
	localparam int CTL1_SCAN_MODE = 1;
	localparam int CTL1_INDICATOR_MODE = 2;
	localparam int CTL1_SENSE_PULL = 4;
	localparam int CTL1_KEY_PULL = 5;
	localparam int TMRH_COUNT_BIT_EIGHT = 0;
	localparam int TMRH_OUTPUT_ENABLE = 1;
	localparam int TMRH_DONE = 2;

	// ----------------------------------------------------------------
	// Timing counts in fx cycles
	// ----------------------------------------------------------------
	localparam logic [7:0] TICK_DIV_FULL = 8'h40;
	localparam logic [7:0] TICK_DIV_HALF = 8'h80;
	localparam logic [7:0] CARRIER_PERIOD_FAST = 8'h08;
	localparam logic [7:0] CARRIER_PERIOD_MID = 8'h40;
	localparam logic [7:0] CARRIER_PERIOD_SLOW = 8'h60;

	typedef enum logic [1:0] {
		CAR_FAST = 2'b00,
		CAR_MID = 2'b01,
		CAR_SLOW = 2'b10,
		CAR_SLOW_THIRD = 2'b11
	} kit_carrier_t;

endpackage : kit_pkg

// >>> logic/kit_carrier_gen.sv
// Purpose: Infrared carrier waveform generator
// Assumes: Single mclk domain, synchronous active-low reset
// Notes: Restart realigns the phase, so the first high phase is full length
`timescale 1ns/1ps
`default_nettype none

module kit_carrier_gen (
	input wire logic mclk, // System clock fx
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic [1:0] carrierSel, // Carrier select bits
	input wire logic halfRate, // Halve carrier frequency
	input wire logic restart, // Restart phase at timer start
	output logic carrierHigh // Carrier level
);

	// ----------------------------------------------------------------
	// Period and high-width lookup
	// ----------------------------------------------------------------
	function automatic logic [7:0] period_of(input logic [1:0] sel, input logic half);
		logic [7:0] base;
		base = kit_pkg::CARRIER_PERIOD_SLOW;
		case (kit_pkg::kit_carrier_t'(sel))
			kit_pkg::CAR_FAST: base = kit_pkg::CARRIER_PERIOD_FAST;
			kit_pkg::CAR_MID: base = kit_pkg::CARRIER_PERIOD_MID;
			default: base = kit_pkg::CARRIER_PERIOD_SLOW;
		endcase
		period_of = half ? {base[6:0], 1'b0} : base;
	endfunction : period_of

	logic [7:0] period;
	logic [7:0] highLen;
	logic [7:0] phase_q;
	logic [7:0] phaseNext;

	// Wrap and restart both return to phase zero, the start of the high part
	assign phaseNext = (restart || phase_q >= period - 8'h01) ? 8'h00 : phase_q + 8'h01;

	always_comb begin
		period = period_of(carrierSel, halfRate);
		if (carrierSel == kit_pkg::CAR_SLOW_THIRD)
			highLen = period / 8'h03;
		else
			highLen = {1'b0, period[7:1]};
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			phase_q <= 8'h00;
		else
			phase_q <= phaseNext;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			carrierHigh <= 1'b0;
		else
			carrierHigh <= phaseNext < highLen;
	end

endmodule : kit_carrier_gen

`default_nettype wire

// >>> dv/kit_port_timer_monitor.sv
// Purpose: Port-level assertions for the key port and carrier timer
// Assumes: One clock, synchronous active-low reset
// Notes: Bound into every kit_port_timer instance
`timescale 1ns/1ps
`default_nettype none

module kit_port_timer_monitor (
	input wire logic mclk, // System clock
	input wire logic rst_n, // Reset, active low
	input wire logic [2:0] regAddr, // Register index
	input wire logic [7:0] regWdata, // Write data
	input wire logic regWe, // Write strobe
	input wire logic regRe, // Read strobe
	input wire logic [7:0] regRdata, // Read data
	input wire logic [7:0] scanPinOut, // Scan latch copy
	input wire logic scanPinOe_n, // Scan drive enable
	input wire logic scanPullEn, // Scan pull-downs
	input wire logic firstSenseEnable, // Sense buffer on
	input wire logic firstSensePullEn, // Sense pull-down
	input wire logic senseIndicatorPinOe_n, // Combined pin drive enable
	input wire logic senseIndicatorPullEn, // Combined pin pull-down
	input wire logic irTransmitPin, // IR output
	input wire logic [1:0] romPointerHigh, // ROM pointer top bits
	input wire logic timerDone // Timer stopped
);
	// ----
	// Assertions
	// ----
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	a_ctl0_fixed: assert property (regRe && regAddr == 3'h3 |=> regRdata[7:6] == 2'b00)
		else $error("control0 top bits not zero");
	a_ctl1_fixed: assert property (regRe && regAddr == 3'h4 |=> (regRdata & 8'hc8) == 8'h00)
		else $error("control1 fixed bits not zero");
	a_status_ones: assert property (regRe && regAddr == 3'h1 |=> regRdata[1:0] == 2'b11)
		else $error("status low bits not one");
	a_scan_latch: assert property (regWe && regAddr == 3'h0 |-> ##2 scanPinOut == $past(regWdata, 2))
		else $error("scan latch not updated");
	a_rom_pointer: assert property (regWe && regAddr == 3'h3 |-> ##2 romPointerHigh == $past(regWdata[5:4], 2))
		else $error("pointer bits wrong");
	a_scan_pull: assert property (scanPullEn == scanPinOe_n)
		else $error("scan pull-down outside input mode");
	a_sense_pull: assert property (firstSensePullEn |-> firstSenseEnable)
		else $error("sense pull-down while off");
	a_ind_pull: assert property (senseIndicatorPullEn |-> senseIndicatorPinOe_n)
		else $error("combined pin pull-down while driving");
	a_done_hold: assert property (timerDone && !(regWe && regAddr == 3'h6) |=> timerDone)
		else $error("done dropped without load");
	a_run_min: assert property ($fell(timerDone) |-> !timerDone [*8])
		else $error("timer run too short");
	a_ir_stops: assert property ($rose(timerDone) |-> ##[0:200] !irTransmitPin)
		else $error("transmit not low after stop");
endmodule : kit_port_timer_monitor

bind kit_port_timer kit_port_timer_monitor i_mon (.mclk, .rst_n, .regAddr, .regWdata, .regWe,
	.regRe, .regRdata, .scanPinOut, .scanPinOe_n, .scanPullEn, .firstSenseEnable,
	.firstSensePullEn, .senseIndicatorPinOe_n, .senseIndicatorPullEn, .irTransmitPin,
	.romPointerHigh, .timerDone);

`default_nettype wire

// >>> dv/kit_pad_model.sv
// Purpose: Key matrix, sense switches and indicator pad model
// Assumes: Pressed key drives high, pull-downs hold the rest low
// Notes: Resolves each pad from the driving party
`timescale 1ns/1ps
`default_nettype none

module kit_pad_model (
	input wire logic [7:0] scanPinOut, // Port latch
	input wire logic scanPinOe_n, // Port drives when low
	input wire logic [7:0] keyPress, // Keys closed on scan lines
	input wire logic [3:0] keyRet, // Key-return levels
	input wire logic sense0, // First sense switch
	input wire logic sense1, // Combined pin switch
	input wire logic firstSenseEnable, // Sense buffer on
	input wire logic senseIndicatorPinOut, // Indicator value
	input wire logic senseIndicatorPinOe_n, // Indicator drives when low
	output logic [7:0] scanPinIn, // Scan pads
	output logic [3:0] keyReturnIn, // Key-return pads
	output logic firstSenseInput, // First sense pad
	output logic senseIndicatorPinIn // Combined pad
);
	assign scanPinIn = scanPinOe_n ? keyPress : scanPinOut;
	assign keyReturnIn = keyRet;
	// Floating pad in off mode carries a meaningless level
	assign firstSenseInput = firstSenseEnable ? sense0 : ~sense0;
	assign senseIndicatorPinIn = senseIndicatorPinOe_n ? sense1 : senseIndicatorPinOut;
endmodule : kit_pad_model

`default_nettype wire

// >>> dv/keypad_port_ir_carrier_timer_bench.sv
// Purpose: Self-checking bench for kit_port_timer
// Assumes: Register reads return data one cycle after the strobe
// Notes: Pads resolved by kit_pad_model
`timescale 1ns/1ps
`default_nettype none

module keypad_port_ir_carrier_timer_bench;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [2:0] regAddr = 3'h0;
	logic [7:0] regWdata = 8'h00;
	logic regWe = 1'b0;
	logic regRe = 1'b0;
	logic [7:0] keyPress = 8'h00;
	logic [3:0] keyRet = 4'h0;
	logic sense0 = 1'b0;
	logic sense1 = 1'b0;
	logic [7:0] regRdata, scanPinIn, scanPinOut;
	logic [3:0] keyReturnIn;
	logic [1:0] romPointerHigh;
	logic scanPinOe_n, scanPullEn, keyPullEn, firstSenseInput, firstSenseEnable;
	logic firstSensePullEn, senseIndicatorPinIn, senseIndicatorPinOut;
	logic senseIndicatorPinOe_n, senseIndicatorPullEn, irTransmitPin, timerDone;
	int errors = 0;
	int samples_checked = 0;

	kit_port_timer i_dut (.mclk, .rst_n, .regAddr, .regWdata, .regWe, .regRe, .regRdata,
		.scanPinIn, .scanPinOut, .scanPinOe_n, .scanPullEn, .keyReturnIn, .keyPullEn,
		.firstSenseInput, .firstSenseEnable, .firstSensePullEn, .senseIndicatorPinIn,
		.senseIndicatorPinOut, .senseIndicatorPinOe_n, .senseIndicatorPullEn,
		.irTransmitPin, .romPointerHigh, .timerDone);
	kit_pad_model i_pads (.scanPinOut, .scanPinOe_n, .keyPress, .keyRet, .sense0, .sense1,
		.firstSenseEnable, .senseIndicatorPinOut, .senseIndicatorPinOe_n, .scanPinIn,
		.keyReturnIn, .firstSenseInput, .senseIndicatorPinIn);

	initial begin
		forever #20 mclk = ~mclk;
	end

	// ----
	// Bus and check tasks
	// ----
	task automatic complete_run();
		if (errors == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWdata <= d;
		regWe <= 1'b1;
		@(posedge mclk);
		regWe <= 1'b0;
	endtask : wr

	task automatic rc(input logic [2:0] a, input logic [7:0] exp);
		@(posedge mclk);
		regAddr <= a;
		regRe <= 1'b1;
		@(posedge mclk);
		regRe <= 1'b0;
		#1;
		chk(regRdata, exp);
	endtask : rc

	// Cycles the output holds level v, sampled after each edge
	task automatic span(input logic v, output int n);
		n = 0;
		while (irTransmitPin === v && n < 2000) begin
			n++;
			@(posedge mclk);
			#1;
		end
	endtask : span

	// ----
	// Scenarios
	// ----
	task automatic t_reset();
		rc(3'h3, 8'h03);
		rc(3'h4, 8'h26);
		rc(3'h0, 8'hff);
		chk({senseIndicatorPinOut, keyPullEn, firstSenseEnable, timerDone, irTransmitPin}, 8'h1a);
		chk(scanPinOe_n, 8'h00);
		rc(3'h1, 8'h0f);
	endtask : t_reset

	task automatic t_regs();
		wr(3'h3, 8'hff);
		rc(3'h3, 8'h3f);
		chk(romPointerHigh, 8'h03);
		wr(3'h4, 8'hff);
		rc(3'h4, 8'h37);
		wr(3'h7, 8'h55);
		rc(3'h2, 8'h00);
		wr(3'h3, 8'h03);
		wr(3'h4, 8'h26);
	endtask : t_regs

	task automatic t_scan();
		wr(3'h0, 8'h5a);
		rc(3'h0, 8'h5a);
		keyPress <= 8'h81;
		wr(3'h4, 8'h24);
		wr(3'h0, 8'h3c);
		repeat (4) @(posedge mclk);
		rc(3'h0, 8'h81);
		chk({scanPullEn, scanPinOe_n}, 8'h03);
		wr(3'h4, 8'h26);
		rc(3'h0, 8'h3c);
	endtask : t_scan

	task automatic t_sense();
		keyRet <= 4'ha;
		sense1 <= 1'b1;
		wr(3'h4, 8'h31);
		repeat (4) @(posedge mclk);
		rc(3'h1, 8'hab);
		chk({firstSensePullEn, senseIndicatorPullEn, senseIndicatorPinOe_n}, 8'h07);
		wr(3'h4, 8'h06);
		repeat (4) @(posedge mclk);
		rc(3'h1, 8'haf);
		chk({keyPullEn, firstSensePullEn, senseIndicatorPullEn}, 8'h00);
		wr(3'h4, 8'h26);
	endtask : t_sense

	task automatic t_timer(input logic half);
		int n;
		wr(3'h3, {4'h0, half, 3'h7});
		wr(3'h5, 8'h02);
		wr(3'h6, 8'h02);
		@(posedge mclk);
		#1;
		chk({senseIndicatorPinOut, irTransmitPin}, 8'h01);
		n = 1;
		while (timerDone === 1'b0 && n < 70000) begin
			n++;
			@(posedge mclk);
			#1;
		end
		chk(n, half ? 16'h0180 : 16'h00c0);
		repeat (2) @(posedge mclk);
		#1;
		chk({senseIndicatorPinOut, irTransmitPin}, 8'h02);
	endtask : t_timer

	task automatic t_zero();
		wr(3'h5, 8'h00);
		wr(3'h6, 8'h02);
		repeat (3) @(posedge mclk);
		#1;
		chk({timerDone, irTransmitPin}, 8'h02);
	endtask : t_zero

	task automatic t_carrier(input logic [1:0] sel, input logic half, input logic [15:0] hi,
			input logic [15:0] lo);
		int n;
		int h;
		int l;
		wr(3'h3, {4'h0, half, 1'b0, sel});
		wr(3'h5, 8'h07);
		wr(3'h6, 8'h02);
		#1;
		span(1'b1, n);
		span(1'b0, n);
		span(1'b1, h);
		span(1'b0, l);
		chk(h, hi);
		chk(l, lo);
		n = 0;
		while (timerDone !== 1'b1 && n < 2000) begin
			n++;
			@(posedge mclk);
		end
		chk(timerDone, 8'h01);
		repeat (130) @(posedge mclk);
		#1;
		chk(irTransmitPin, 8'h00);
	endtask : t_carrier

	initial begin
		#2000000;
		errors++;
		complete_run();
	end

	initial begin
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		t_reset();
		t_regs();
		t_scan();
		t_sense();
		t_timer(1'b0);
		t_timer(1'b1);
		t_zero();
		t_carrier(2'h0, 1'b0, 16'h0004, 16'h0004);
		t_carrier(2'h1, 1'b0, 16'h0020, 16'h0020);
		t_carrier(2'h2, 1'b0, 16'h0030, 16'h0030);
		t_carrier(2'h3, 1'b0, 16'h0020, 16'h0040);
		t_carrier(2'h0, 1'b1, 16'h0008, 16'h0008);
		t_carrier(2'h3, 1'b1, 16'h0040, 16'h0080);
		complete_run();
	end
endmodule : keypad_port_ir_carrier_timer_bench

`default_nettype wire
